// [common/cev_pkg.sv]
/*
 * Shared constants for the exception vectoring block: priority ranks,
 * handler offsets, reset address and the widths used by the ports.
 * Assumes a 32-bit address space and halfword-aligned instructions.
 */
package cev_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned RANK_W = 5;

    // fixed reset entry, independent of the vector base
    localparam logic [31:0] RESET_ADDR = 32'h8000_0000;
    localparam logic [31:0] SCALL_RET_INC = 32'h0000_0002;

    // priority ranks
    localparam logic [4:0] RANK_RESET = 5'h01;
    localparam logic [4:0] RANK_NMI   = 5'h07;
    localparam logic [4:0] RANK_IRQ3  = 5'h08;
    localparam logic [4:0] RANK_BRK   = 5'h0F;
    localparam logic [4:0] RANK_ILL   = 5'h10;
    localparam logic [4:0] RANK_UNIMP = 5'h11;
    localparam logic [4:0] RANK_PRIV  = 5'h12;
    localparam logic [4:0] RANK_FP    = 5'h13;
    localparam logic [4:0] RANK_COP   = 5'h14;
    localparam logic [4:0] RANK_SCALL = 5'h15;
    localparam logic [4:0] RANK_DAR   = 5'h16;
    localparam logic [4:0] RANK_DAW   = 5'h17;
    localparam logic [4:0] RANK_DMR   = 5'h18;
    localparam logic [4:0] RANK_DMW   = 5'h19;
    localparam logic [4:0] RANK_DPR   = 5'h1A;
    localparam logic [4:0] RANK_DPW   = 5'h1B;
    localparam logic [4:0] RANK_DMOD  = 5'h1C;

    // handler offsets from the vector base
    localparam logic [31:0] OFS_NMI   = 32'h0000_0010;
    localparam logic [31:0] OFS_BRK   = 32'h0000_001C;
    localparam logic [31:0] OFS_ILL   = 32'h0000_0020;
    localparam logic [31:0] OFS_UNIMP = 32'h0000_0024;
    localparam logic [31:0] OFS_PRIV  = 32'h0000_0028;
    localparam logic [31:0] OFS_FP    = 32'h0000_002C;
    localparam logic [31:0] OFS_COP   = 32'h0000_0030;
    localparam logic [31:0] OFS_SCALL = 32'h0000_0100;
    localparam logic [31:0] OFS_DAR   = 32'h0000_0034;
    localparam logic [31:0] OFS_DAW   = 32'h0000_0038;
    localparam logic [31:0] OFS_DMR   = 32'h0000_0060;
    localparam logic [31:0] OFS_DMW   = 32'h0000_0070;
    localparam logic [31:0] OFS_DPR   = 32'h0000_003C;
    localparam logic [31:0] OFS_DPW   = 32'h0000_0040;
    localparam logic [31:0] OFS_DMOD  = 32'h0000_0044;

    // one-hot vectoring states
    typedef enum logic [1:0] {
        CEV_ST_RESET = 2'b01,
        CEV_ST_RUN   = 2'b10
    } cev_state_t;

endpackage

// [verification/cev_pipe_model.sv]
/*
 * Far-side model of the pipeline, debug system and protection unit.
 * Assumes the bench hands it one request bit per event, in rank order,
 * changed just after a rising clock edge.
 */
`timescale 1ns/1ps

module cev_pipe_model (
    // requests from the bench
    input  wire logic [16:0] ev_in,
    input  wire logic [31:0] fpc_in,
    input  wire logic [31:0] upc_in,
    // pins toward the vectoring block
    output logic             nmi_out,
    output logic [3:0]       irq_out,
    output logic [11:0]      evt_out,
    output logic [31:0]      fpc_out,
    output logic [31:0]      upc_out
);
    // bit 1 is the most urgent interrupt level
    assign nmi_out = ev_in[0];
    assign irq_out = {ev_in[1], ev_in[2], ev_in[3], ev_in[4]};
    assign evt_out = ev_in[16:5];
    // no fault from bit 6 up in flight (for upc, no event at all): pcs are not held, so show junk, not the last value
    assign fpc_out = |ev_in[16:6] ? fpc_in : ~fpc_in;
    assign upc_out = |ev_in ? upc_in : ~upc_in;
endmodule // cev_pipe_model

// [verification/tb.sv]
/*
 * Self-checking bench for the exception vectoring block.
 * Assumes a 50 MHz clock and that outputs settle one cycle after sampling.
 */
`timescale 1ns/1ps

module tb
    import cev_pkg::*;
;
    logic        clk_in, rst_n_in, app, prot, nmi, redir;
    logic [31:0] base, avec, fpc, upc, seed, fpc_w, upc_w, hnd, ret;
    logic [16:0] ev, rev;
    logic [3:0]  irq;
    logic [11:0] evt;
    logic [4:0]  rnk;
    int          checked, miscompares;
    // offsets in rank order; the irq slots are autovectored
    logic [11:0] ofs [17] = '{12'h010, 12'h000, 12'h000, 12'h000, 12'h000, 12'h01C,
        12'h020, 12'h024, 12'h028, 12'h030, 12'h100, 12'h034, 12'h038, 12'h060,
        12'h070, 12'h03C, 12'h040};

    cev_pipe_model pm_u (.ev_in(ev), .fpc_in(fpc), .upc_in(upc), .nmi_out(nmi),
        .irq_out(irq), .evt_out(evt), .fpc_out(fpc_w), .upc_out(upc_w));

    cev_vector dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .exception_vector_base_in(base), .app_mode_in(app), .sys_stack_protected_in(prot),
        .nmi_in(nmi), .irq_in(irq), .irq_autovector_in(avec),
        .first_uncompleted_pc_in(upc_w), .breakpoint_in(evt[0]),
        .illegal_opcode_in(evt[1]), .unimplemented_in(evt[2]), .privilege_in(evt[3]),
        .cop_absent_in(evt[4]), .scall_in(evt[5]), .fault_pc_in(fpc_w),
        .data_addr_rd_in(evt[6]), .data_addr_wr_in(evt[7]), .dtb_miss_rd_in(evt[8]),
        .dtb_miss_wr_in(evt[9]), .mpu_prot_rd_in(evt[10]), .mpu_prot_wr_in(evt[11]),
        .redirect_out(redir), .handler_addr_out(hnd), .return_addr_out(ret),
        .rank_out(rnk));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // rank of the event at index i of the request vector
    function automatic logic [4:0] rk(input int i);
        return 5'(i == 0 ? 7 : i < 5 ? 7 + i : i < 9 ? 10 + i : 11 + i);
    endfunction

    task automatic chk_addr(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_rank(input string n, input logic [4:0] e, input logic [4:0] g);
        chk_addr(n, {27'h0, e}, {27'h0, g});
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_addr(n, {31'h0, e}, {31'h0, g});
    endtask

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // reset for three cycles, then the fixed reset entry
    task automatic do_reset();
        @(posedge clk_in) rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk_bit("reset redirect", 1'b0, redir);
        chk_rank("reset rank", 5'h01, rnk);
        @(posedge clk_in) rst_n_in <= 1'b1;
        @(posedge clk_in) #1;
        chk_bit("entry redirect", 1'b1, redir);
        chk_addr("entry handler", 32'h8000_0000, hnd);
        chk_rank("entry rank", 5'h01, rnk);
    endtask

    // one event set, held for one cycle; expectation worked out here
    task automatic send(input logic [16:0] e, input logic a, input logic p);
        logic [16:0] f;
        logic        sf;
        int          i;
        logic [31:0] er, eh;
        seed = xs(seed);
        @(posedge clk_in)
        begin
            ev <= e;
            app <= a;
            prot <= p;
            fpc <= seed & 32'hFFFF_FFFE;
            upc <= {seed[15:0], seed[31:16]} & 32'hFFFF_FFFE;
        end
        @(posedge clk_in) ev <= '0;
        #1;
        sf = a && p && |e[4:0];
        f = sf ? {1'b1, e[15:5], 5'h00} : e;
        i = 0;
        while (i < 16 && !f[i])
            i++;
        // irq slots take the autovector; the stack fault returns to the interrupted pc
        eh = (i > 0 && i < 5) ? avec : base + {20'h0, ofs[i]};
        er = (i < 6 || (i == 16 && sf && !e[16])) ? upc : i == 10 ? fpc + 32'h2 : fpc;
        chk_bit("redirect", |e, redir);
        if (|e)
        begin
            chk_addr("handler", eh, hnd);
            if (i < 13 || i > 14)
                chk_addr("return", er, ret);
            chk_rank("rank", rk(i), rnk);
        end
    endtask

    initial
    begin
        rst_n_in = 1'b0;
        ev = '0;
        app = 1'b0;
        prot = 1'b0;
        seed = 32'h57e3;
        base = 32'h0001_2000;
        avec = 32'h0003_4560;
        fpc = '0;
        upc = '0;
        checked = 0;
        miscompares = 0;
        do_reset();
        for (int k = 0; k < 9; k++)
            send(17'h1 << k, 1'b0, 1'b1);
        for (int k = 9; k < 17; k++)
            send(17'h1 << k, 1'b0, 1'b1);
        send(17'h1FFFF, 1'b0, 1'b0);
        send(17'h00004, 1'b1, 1'b1);
        send(17'h10001, 1'b1, 1'b1);
        send(17'h00020, 1'b1, 1'b1);
        for (int k = 0; k < 300; k++)
        begin
            seed = xs(seed);
            // new base on an idle edge; the last redirect must have dropped
            @(posedge clk_in)
            begin
                base <= {seed[31:8], 8'h00};
                avec <= seed & 32'hFFFF_FFFE;
            end
            #1;
            chk_bit("idle redirect", 1'b0, redir);
            rev = seed[20] ? 17'h1 << (seed[12:8] % 17) : seed[16:0] & seed[31:15];
            send(rev, seed[3], seed[5]);
            if (k == 150)
                do_reset();
        end
        stop_test();
    end
endmodule // tb

// [verilog/cev_vector.sv]
/*
 * Exception prioritisation and vectoring for a three-stage core.
 * Assumes event inputs are single-cycle requests synchronous to clk_in,
 * each carrying the program counter of the instruction it concerns, and
 * that fetch follows redirect_out whenever it pulses.
 */
`timescale 1ns/1ps

// Contract
// (RULE1) breakpoint rank 15, base+0x1C, first uncompleted
// (RULE2) illegal opcode rank 16, base+0x20, faulting pc
// (RULE3) unimplemented instruction rank 17, base+0x24, pc
// (RULE4) privilege violation rank 18, base+0x28, pc
// (RULE5) floating-point slot 19 never raised
// (RULE6) coprocessor absent rank 20, base+0x30, pc
// (RULE7) supervisor call rank 21, base+0x100, pc+2
// (RULE8) data address read/write ranks 22/23, 0x34/0x38
// (RULE9) translation miss read/write ranks 24/25, 0x60/0x70
// (RULE10) protection fault read/write ranks 26/27, 0x3C/0x40
// (RULE11) translation-modified slot 28 never raised
// (RULE12) app-mode interrupt, protected stack: protection write fault
// (RULE13) reset rank 1, start 0x8000_0000, return undefined
// (RULE14) nmi rank 7 base+0x10; irq ranks 8-11 autovectored
// (RULE15) smallest rank wins; handler is base plus offset
module cev_vector
    import cev_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    // vector base and mode
    input  wire logic [ADDR_W-1:0] exception_vector_base_in,
    input  wire logic              app_mode_in,
    input  wire logic              sys_stack_protected_in,
    // interrupt requests
    input  wire logic              nmi_in,
    input  wire logic [3:0]        irq_in,
    input  wire logic [ADDR_W-1:0] irq_autovector_in,
    input  wire logic [ADDR_W-1:0] first_uncompleted_pc_in,
    // on_chip_debug_system
    input  wire logic              breakpoint_in,
    // decode-stage faults
    input  wire logic              illegal_opcode_in,
    input  wire logic              unimplemented_in,
    input  wire logic              privilege_in,
    input  wire logic              cop_absent_in,
    input  wire logic              scall_in,
    input  wire logic [ADDR_W-1:0] fault_pc_in,
    // data address faults
    input  wire logic              data_addr_rd_in,
    input  wire logic              data_addr_wr_in,
    // data_translation_buffer / memory_protection_unit
    input  wire logic              dtb_miss_rd_in,
    input  wire logic              dtb_miss_wr_in,
    input  wire logic              mpu_prot_rd_in,
    input  wire logic              mpu_prot_wr_in,
    // fetch redirection
    output logic                   redirect_out,
    output logic [ADDR_W-1:0]      handler_addr_out,
    output logic [ADDR_W-1:0]      return_addr_out,
    output logic [RANK_W-1:0]      rank_out
);

    cev_state_t        state_r;
    logic              hit_nxt;
    logic [ADDR_W-1:0] ofs_nxt;
    logic [ADDR_W-1:0] ret_nxt;
    logic [RANK_W-1:0] rank_nxt;
    logic              autovec_nxt;
    logic              stack_fault;
    logic [ADDR_W-1:0] handler_nxt;

    // interrupt entry from application mode pushes onto a protected stack
    assign stack_fault = app_mode_in && sys_stack_protected_in
                       && (nmi_in || (|irq_in)); // [RULE12]

    // fixed priority chain: first match is the smallest rank
    always_comb
    begin
        hit_nxt     = 1'b1;
        ofs_nxt     = '0;
        ret_nxt     = fault_pc_in;
        rank_nxt    = '0;
        autovec_nxt = 1'b0;
        if (nmi_in && !stack_fault)
        begin
            rank_nxt = RANK_NMI; // [RULE14]
            ofs_nxt  = OFS_NMI;
            ret_nxt  = first_uncompleted_pc_in;
        end
        else if ((|irq_in) && !stack_fault)
        begin
            // autovectored; level 3 is the most urgent
            autovec_nxt = 1'b1; // [RULE14]
            ret_nxt     = first_uncompleted_pc_in;
            if (irq_in[3])
                rank_nxt = RANK_IRQ3;
            else if (irq_in[2])
                rank_nxt = RANK_IRQ3 + 5'h01;
            else if (irq_in[1])
                rank_nxt = RANK_IRQ3 + 5'h02;
            else
                rank_nxt = RANK_IRQ3 + 5'h03;
        end
        else if (breakpoint_in)
        begin
            rank_nxt = RANK_BRK; // [RULE1]
            ofs_nxt  = OFS_BRK;
            ret_nxt  = first_uncompleted_pc_in;
        end
        else if (illegal_opcode_in)
        begin
            rank_nxt = RANK_ILL; // [RULE2]
            ofs_nxt  = OFS_ILL;
        end
        else if (unimplemented_in)
        begin
            rank_nxt = RANK_UNIMP; // [RULE3]
            ofs_nxt  = OFS_UNIMP;
        end
        else if (privilege_in)
        begin
            rank_nxt = RANK_PRIV; // [RULE4]
            ofs_nxt  = OFS_PRIV;
        end
        else if (cop_absent_in)
        begin
            rank_nxt = RANK_COP; // [RULE6]
            ofs_nxt  = OFS_COP;
        end
        else if (scall_in)
        begin
            rank_nxt = RANK_SCALL; // [RULE7]
            ofs_nxt  = OFS_SCALL;
            ret_nxt  = fault_pc_in + SCALL_RET_INC;
        end
        else if (data_addr_rd_in)
        begin
            rank_nxt = RANK_DAR; // [RULE8]
            ofs_nxt  = OFS_DAR;
        end
        else if (data_addr_wr_in)
        begin
            rank_nxt = RANK_DAW; // [RULE8]
            ofs_nxt  = OFS_DAW;
        end
        else if (dtb_miss_rd_in)
        begin
            rank_nxt = RANK_DMR; // [RULE9]
            ofs_nxt  = OFS_DMR;
        end
        else if (dtb_miss_wr_in)
        begin
            rank_nxt = RANK_DMW; // [RULE9]
            ofs_nxt  = OFS_DMW;
        end
        else if (mpu_prot_rd_in)
        begin
            rank_nxt = RANK_DPR; // [RULE10]
            ofs_nxt  = OFS_DPR;
        end
        else if (mpu_prot_wr_in || stack_fault)
        begin
            rank_nxt = RANK_DPW; // [RULE10] [RULE12]
            ofs_nxt  = OFS_DPW;
            if (stack_fault && !mpu_prot_wr_in)
                ret_nxt = first_uncompleted_pc_in;
        end
        else
        begin
            // floating-point and translation-modified slots have no source
            hit_nxt = 1'b0; // [RULE5] [RULE11]
        end
    end

    // handler is base plus offset, or the interrupt autovector
    assign handler_nxt = autovec_nxt ? irq_autovector_in
                       : exception_vector_base_in + ofs_nxt; // [RULE15]

    // reset entry first, then normal vectoring
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_r <= CEV_ST_RESET;
        else
        begin
            case (state_r)
                CEV_ST_RESET: state_r <= CEV_ST_RUN;
                CEV_ST_RUN:   state_r <= CEV_ST_RUN;
                default:      state_r <= CEV_ST_RESET;
            endcase
        end
    end

    // registered redirect; return address left at zero for reset
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            redirect_out     <= 1'b0;
            handler_addr_out <= RESET_ADDR;
            return_addr_out  <= '0;
            rank_out         <= RANK_RESET;
        end
        else if (state_r == CEV_ST_RESET)
        begin
            // fixed start, ignores the vector base
            redirect_out     <= 1'b1; // [RULE13]
            handler_addr_out <= RESET_ADDR;
            rank_out         <= RANK_RESET;
        end
        else
        begin
            redirect_out <= hit_nxt;
            if (hit_nxt)
            begin
                handler_addr_out <= handler_nxt;
                return_addr_out  <= ret_nxt;
                rank_out         <= rank_nxt;
            end
        end
    end

    // supervisor call returns past the two-byte call
    scall_ret_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == CEV_ST_RUN && scall_in && !nmi_in && irq_in == 4'h0
         && !breakpoint_in && !illegal_opcode_in && !unimplemented_in
         && !privilege_in && !cop_absent_in)
        |=> (return_addr_out == $past(fault_pc_in) + 32'h0000_0002
             && rank_out == 5'h15))
        else $error("supervisor call return address wrong"); // [RULE7]

    // breakpoint beats decode faults
    brk_prio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == CEV_ST_RUN && breakpoint_in && !nmi_in && irq_in == 4'h0)
        |=> (rank_out == 5'h0F && redirect_out
             && handler_addr_out == $past(exception_vector_base_in) + 32'h0000_001C))
        else $error("breakpoint not vectored"); // [RULE1]

    // illegal opcode vector
    ill_vec_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rank_out == 5'h10 && redirect_out)
        |-> handler_addr_out == $past(exception_vector_base_in) + 32'h0000_0020)
        else $error("illegal opcode vector wrong"); // [RULE2]

    // translation miss write vector
    miss_wr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rank_out == 5'h19 && redirect_out)
        |-> handler_addr_out == $past(exception_vector_base_in) + 32'h0000_0070)
        else $error("translation miss write vector wrong"); // [RULE9]

    // unused slots never appear
    no_unused_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        redirect_out |-> (rank_out != 5'h13 && rank_out != 5'h1C))
        else $error("unused event slot raised"); // [RULE5] [RULE11]

    // first redirect after reset goes to the fixed address
    reset_entry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(redirect_out) && $past(state_r) == CEV_ST_RESET
        |-> (handler_addr_out == 32'h8000_0000 && rank_out == 5'h01))
        else $error("reset entry address wrong"); // [RULE13]

    // stack fault on protected interrupt entry
    stack_flt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == CEV_ST_RUN && stack_fault && !breakpoint_in
         && !illegal_opcode_in && !unimplemented_in && !privilege_in
         && !cop_absent_in && !scall_in && !data_addr_rd_in && !data_addr_wr_in
         && !dtb_miss_rd_in && !dtb_miss_wr_in && !mpu_prot_rd_in)
        |=> rank_out == 5'h1B)
        else $error("protected stack fault missing"); // [RULE12]

    // nmi outranks everything below it
    nmi_prio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == CEV_ST_RUN && nmi_in && !stack_fault)
        |=> (rank_out == 5'h07
             && handler_addr_out == $past(exception_vector_base_in) + 32'h0000_0010))
        else $error("nmi not vectored first"); // [RULE14] [RULE15]

endmodule // cev_vector
